// file: include/adcsp_pkg.sv
// Summary of operation
// - Spend 1624 master cycles computing each word before trying to load it.
// - Raise result_ready_n two master cycles before each attempted port update.
// - Load only if port empty or select is high; else keep unread word.
// - Drive result_ready_n low whenever a new word is loaded.
// - Mode pin at supply selects self clocking; at ground selects host clocking.
// - In self clocked mode the device drives data and shift clock.
// - Self clocked, select low: pins leave high-Z two cycles after ready falls.
// - Self clocked: MSB held two master cycles, shift clock rising midway.
// - Self clocked: later bits appear on falling edges of the shift clock.
// - Self clocked: clock fall after LSB tri-states pins, ready goes high.
// - Self clocked: late select shows MSB four master cycles after the select pin falls.
// - Self clocked: select high mid-bit finishes that bit, then tri-states.
// - Host may reselect before next conversion; remaining bits then continue.
// - Host clocked: select low with data drives data pin with MSB.
// - Host clocked: second clock rise arms shifting; later falls advance bits.
// - Host clocked: a fall before arming is ignored.
// - Host clocked: fall while LSB is driven tri-states data, ready high.
// - Bipolar results are offset by mid-scale, 8000 or 80000 hex.
// - Mid-level mode pin puts the port to sleep: idle, tri-stated, unread word kept.
`default_nettype none

package adcsp_pkg;

  localparam int           CONVERT_REQUEST_CYCLES = 1624;
  localparam int           READY_LEAD  = 2;
  localparam int           PORT_DELAY  = 2;
  localparam int           WORD_W      = 16;
  localparam logic [15:0]  MID_16      = 16'h8000;
  localparam logic [19:0]  MID_20      = 20'h80000;
  localparam logic [1:0]   MODE_GND    = 2'h0;
  localparam logic [1:0]   MODE_MID    = 2'h1;
  localparam logic [1:0]   MODE_SUP    = 2'h3;
  localparam logic [10:0]  CNT_LAST    = 11'(CONVERT_REQUEST_CYCLES - 1);
  localparam logic [10:0]  CNT_LEAD    = 11'(CONVERT_REQUEST_CYCLES - 1 - READY_LEAD);
  localparam logic [1:0]   WAIT_LAST   = 2'(PORT_DELAY - 1);

  typedef enum logic [2:0] {
    ADCSP_IDLE,
    ADCSP_WAIT,
    ADCSP_LOW,
    ADCSP_HIGH,
    ADCSP_EXT
  } adcsp_state_t;

endpackage : adcsp_pkg

`default_nettype wire

// file: rtl/adcsp_port.sv
`default_nettype none

module adcsp_port #(
  parameter int W = adcsp_pkg::WORD_W
) (
  // Clocks, reset, enable
  input  wire logic         core_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic         host_sclk_i,
  // Filter side, same clock
  input  wire logic [W-1:0] result_i,
  // Pins
  input  wire logic         convert_request_i,
  input  wire logic         select_n_i,
  input  wire logic [1:0]   mode_sleep_pin_i,
  input  wire logic         bipolar_i,
  // Serial outputs
  output logic              serial_out_o,
  output logic              serial_out_oe_o,
  output logic              sclk_o,
  output logic              sclk_oe_o,
  output logic              result_ready_n_o
);

  import adcsp_pkg::*;

  localparam logic [W-1:0] MID   = (W == 20) ? W'(MID_20) : W'(MID_16);
  localparam logic [4:0]   TOP   = 5'(W - 1);

  // Pin synchronisers
  logic [5:0] meta_reg;
  logic [5:0] sync_reg;
  logic       tgl_prev_reg;
  logic       shift_tgl_reg;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= 6'h02;
      sync_reg <= 6'h02;
    end else if (ce_i) begin
      meta_reg <= {shift_tgl_reg, bipolar_i, mode_sleep_pin_i,
                   select_n_i, convert_request_i};
      sync_reg <= meta_reg;
    end
  end

  logic       convert_request_s;
  logic       sel_n_s;
  logic [1:0] mode_s;
  logic       bip_s;
  logic       tgl_s;
  logic       sleep;
  logic       self_mode;

  assign convert_request_s    = sync_reg[0];
  assign sel_n_s   = sync_reg[1];
  assign mode_s    = sync_reg[3:2];
  assign bip_s     = sync_reg[4];
  assign tgl_s     = sync_reg[5];
  assign sleep     = (mode_s == MODE_MID);
  assign self_mode = (mode_s == MODE_SUP);

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tgl_prev_reg <= 1'b0;
    end else if (ce_i) begin
      tgl_prev_reg <= tgl_s;
    end
  end

  logic shift_pulse;
  assign shift_pulse = tgl_s ^ tgl_prev_reg;

  // Conversion timing
  logic        converting_reg;
  logic [10:0] convert_request_cnt_reg;
  logic        update;
  logic        lead;

  assign update = converting_reg && (convert_request_cnt_reg == CNT_LAST);
  assign lead   = converting_reg && (convert_request_cnt_reg == CNT_LEAD);

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      converting_reg <= 1'b0;
      convert_request_cnt_reg   <= 11'h000;
    end else if (ce_i) begin
      if (sleep) begin
        converting_reg <= 1'b0;
        convert_request_cnt_reg   <= 11'h000;
      end else if (!converting_reg) begin
        converting_reg <= convert_request_s;
        convert_request_cnt_reg   <= 11'h000;
      end else if (update) begin
        // Back to back while the request stays high
        converting_reg <= convert_request_s;
        convert_request_cnt_reg   <= 11'h000;
      end else begin
        convert_request_cnt_reg <= convert_request_cnt_reg + 11'h001;
      end
    end
  end

  // Port state
  adcsp_state_t   state_reg;
  logic           full_reg;
  logic [W-1:0]   shift_reg;
  logic [4:0]     bit_cnt_reg;
  logic [1:0]     wait_cnt_reg;
  logic           ext_active_reg;
  logic           load;
  logic           done;
  logic [W-1:0]   word_in;

  assign load = update && (!full_reg || sel_n_s);
  assign word_in = bip_s ? W'(result_i + MID) : result_i;

  assign done = (bit_cnt_reg == 5'h00) &&
                (((state_reg == ADCSP_HIGH)) ||
                 ((state_reg == ADCSP_EXT) && shift_pulse));

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      full_reg <= 1'b0;
    end else if (ce_i) begin
      if (load) begin
        full_reg <= 1'b1;
      end else if (done) begin
        full_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_ready_n_o <= 1'b1;
    end else if (ce_i) begin
      if (load) begin
        result_ready_n_o <= 1'b0;
      end else if (lead || done) begin
        result_ready_n_o <= 1'b1;
      end
    end
  end

  // Serial engine; one counter for both modes
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg       <= ADCSP_IDLE;
      shift_reg       <= '0;
      bit_cnt_reg     <= 5'h00;
      wait_cnt_reg    <= 2'h0;
      ext_active_reg  <= 1'b0;
      serial_out_o    <= 1'b0;
      serial_out_oe_o <= 1'b0;
      sclk_o          <= 1'b0;
      sclk_oe_o       <= 1'b0;
    end else if (ce_i) begin
      if (load) begin
        // New word restarts the port from its MSB
        state_reg       <= ADCSP_IDLE;
        shift_reg       <= word_in;
        bit_cnt_reg     <= TOP;
        ext_active_reg  <= 1'b0;
        serial_out_oe_o <= 1'b0;
        sclk_oe_o       <= 1'b0;
        sclk_o          <= 1'b0;
      end else if (sleep) begin
        state_reg       <= ADCSP_IDLE;
        ext_active_reg  <= 1'b0;
        serial_out_oe_o <= 1'b0;
        sclk_oe_o       <= 1'b0;
        sclk_o          <= 1'b0;
      end else begin
        case (state_reg)
          ADCSP_IDLE: begin
            wait_cnt_reg <= 2'h0;
            if (full_reg && !sel_n_s) begin
              if (self_mode) begin
                // Idle cycle counts as the first wait cycle
                state_reg    <= ADCSP_WAIT;
                wait_cnt_reg <= 2'h1;
              end else begin
                state_reg       <= ADCSP_EXT;
                ext_active_reg  <= 1'b1;
                serial_out_o    <= shift_reg[W-1];
                serial_out_oe_o <= 1'b1;
              end
            end
          end
          ADCSP_WAIT: begin
            if (sel_n_s) begin
              state_reg <= ADCSP_IDLE;
            end else if (wait_cnt_reg == WAIT_LAST) begin
              state_reg       <= ADCSP_LOW;
              serial_out_o    <= shift_reg[W-1];
              serial_out_oe_o <= 1'b1;
              sclk_o          <= 1'b0;
              sclk_oe_o       <= 1'b1;
            end else begin
              wait_cnt_reg <= wait_cnt_reg + 2'h1;
            end
          end
          ADCSP_LOW: begin
            // Rise midway through the two cycle bit
            state_reg <= ADCSP_HIGH;
            sclk_o    <= 1'b1;
          end
          ADCSP_HIGH: begin
            sclk_o <= 1'b0;
            if (bit_cnt_reg == 5'h00) begin
              state_reg       <= ADCSP_IDLE;
              serial_out_oe_o <= 1'b0;
              sclk_oe_o       <= 1'b0;
            end else begin
              shift_reg    <= {shift_reg[W-2:0], 1'b0};
              bit_cnt_reg  <= bit_cnt_reg - 5'h01;
              serial_out_o <= shift_reg[W-2];
              if (sel_n_s) begin
                // Bit just finished; rest waits for reselect
                state_reg       <= ADCSP_IDLE;
                serial_out_oe_o <= 1'b0;
                sclk_oe_o       <= 1'b0;
              end else begin
                state_reg <= ADCSP_LOW;
              end
            end
          end
          ADCSP_EXT: begin
            if (shift_pulse && bit_cnt_reg == 5'h00) begin
              state_reg       <= ADCSP_IDLE;
              ext_active_reg  <= 1'b0;
              serial_out_oe_o <= 1'b0;
            end else if (shift_pulse) begin
              shift_reg    <= {shift_reg[W-2:0], 1'b0};
              bit_cnt_reg  <= bit_cnt_reg - 5'h01;
              serial_out_o <= shift_reg[W-2];
            end else if (sel_n_s) begin
              state_reg       <= ADCSP_IDLE;
              ext_active_reg  <= 1'b0;
              serial_out_oe_o <= 1'b0;
            end
          end
          default: begin
            state_reg <= ADCSP_IDLE;
          end
        endcase
      end
    end
  end

  // Host clock domain; the clock may stop between words
  logic act_meta_reg;
  logic armed_reg;

  always_ff @(posedge host_sclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_meta_reg <= 1'b0;
      armed_reg    <= 1'b0;
    end else begin
      act_meta_reg <= ext_active_reg;
      // Arms on a rise while the MSB is out
      armed_reg    <= act_meta_reg;
    end
  end

  // Falls before arming are ignored
  always_ff @(negedge host_sclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_tgl_reg <= 1'b0;
    end else if (armed_reg) begin
      shift_tgl_reg <= ~shift_tgl_reg;
    end
  end

endmodule : adcsp_port

`default_nettype wire

// file: testbench/adcsp_port_monitor.sv
`default_nettype none
module adcsp_port_monitor (
  input wire logic       core_clk_i,
  input wire logic       nrst_i,
  input wire logic       select_n_i,
  input wire logic [1:0] mode_sleep_pin_i,
  input wire logic       serial_out_o,
  input wire logic       serial_out_oe_o,
  input wire logic       sclk_o,
  input wire logic       sclk_oe_o,
  input wire logic       result_ready_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic self_m;
  assign self_m = (mode_sleep_pin_i == adcsp_pkg::MODE_SUP);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_lead;
    $rose(result_ready_n_o) && select_n_i && $past(select_n_i, 4)
      |-> ##2 $fell(result_ready_n_o);
  endproperty
  a_lead: assert property (p_lead) else $error("ready lead wrong");
  property p_load;
    $rose(serial_out_oe_o) |-> !result_ready_n_o;
  endproperty
  a_load: assert property (p_load) else $error("drive without ready");
  property p_mode;
    mode_sleep_pin_i == 2'h0 && $past(mode_sleep_pin_i, 3) == 2'h0
      |-> !sclk_oe_o;
  endproperty
  a_mode: assert property (p_mode) else $error("clock driven");
  property p_pair;
    sclk_oe_o |-> serial_out_oe_o;
  endproperty
  a_pair: assert property (p_pair) else $error("clock without data");
  property p_rel;
    self_m && $fell(result_ready_n_o) && !select_n_i
      && !$past(select_n_i, 3) |-> ##2 serial_out_oe_o;
  endproperty
  a_rel: assert property (p_rel) else $error("pins not released");
  property p_bit;
    $rose(sclk_o) |=> !sclk_o;
  endproperty
  a_bit: assert property (p_bit) else $error("clock high too long");
  property p_fall;
    self_m && sclk_oe_o && $past(sclk_oe_o) && $changed(serial_out_o)
      |-> $fell(sclk_o);
  endproperty
  a_fall: assert property (p_fall) else $error("data off fall");
  property p_end;
    $fell(serial_out_oe_o) && !select_n_i && !$past(select_n_i, 6)
      |-> result_ready_n_o;
  endproperty
  a_end: assert property (p_end) else $error("ready not back");
  property p_late;
    self_m && $fell(select_n_i) && !result_ready_n_o && !serial_out_oe_o
      |-> ##[2:7] serial_out_oe_o;
  endproperty
  a_late: assert property (p_late) else $error("late select slow");
  property p_desel;
    self_m && $rose(select_n_i) && sclk_oe_o |-> ##[1:6] !sclk_oe_o;
  endproperty
  a_desel: assert property (p_desel) else $error("no tri-state");
endmodule : adcsp_port_monitor
bind adcsp_port adcsp_port_monitor u_mon (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .select_n_i(select_n_i),
  .mode_sleep_pin_i(mode_sleep_pin_i), .serial_out_o(serial_out_o),
  .serial_out_oe_o(serial_out_oe_o), .sclk_o(sclk_o),
  .sclk_oe_o(sclk_oe_o), .result_ready_n_o(result_ready_n_o));
`default_nettype wire

// file: testbench/adcsp_host_model.sv
`default_nettype none
module adcsp_host_model #(
  parameter int W = 16
) (
  input  wire logic sclk_i,
  input  wire logic sclk_oe_i,
  input  wire logic data_i,
  output var logic  host_sclk_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [W-1:0] word;
  int           bits;
  initial host_sclk_o = 1'b0;
  always @(posedge sclk_i) begin
    if (sclk_oe_i) begin
      word = {word[W-2:0], data_i};
      bits++;
    end
  end
  // Clock idles low between frames; one extra pulse fills the arming sync
  task automatic ext_read();
    #250;
    for (int i = 0; i <= W; i++) begin
      host_sclk_o = 1'b1;
      if (i > 0) word = {word[W-2:0], data_i};
      #28;
      host_sclk_o = 1'b0;
      #28;
    end
  endtask : ext_read
endmodule : adcsp_host_model
`default_nettype wire

// file: testbench/adcsp_port_tb_top.sv
`default_nettype none
module adcsp_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import adcsp_pkg::*;
  localparam int W = 16;
  logic         clk;
  logic         nrst;
  logic         sel_n;
  logic         req;
  logic         bip;
  logic [1:0]   mode;
  logic [W-1:0] res;
  logic         hclk;
  logic         sdo;
  logic         sdo_oe;
  logic         sclk;
  logic         sclk_oe;
  logic         rdy_n;
  int           failures;
  int           check_count;
  adcsp_port #(.W(W)) DUT (
    .core_clk_i(clk), .nrst_i(nrst), .ce_i(1'b1), .host_sclk_i(hclk),
    .result_i(res), .convert_request_i(req), .select_n_i(sel_n),
    .mode_sleep_pin_i(mode), .bipolar_i(bip), .serial_out_o(sdo),
    .serial_out_oe_o(sdo_oe), .sclk_o(sclk), .sclk_oe_o(sclk_oe),
    .result_ready_n_o(rdy_n));
  adcsp_host_model #(.W(W)) HOST (
    .sclk_i(sclk), .sclk_oe_i(sclk_oe), .data_i(sdo), .host_sclk_o(hclk));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic wait_lvl(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) @(negedge clk);
  endtask : wait_lvl
  task automatic drive_sel(logic v);
    @(posedge clk);
    #1 sel_n = v;
  endtask : drive_sel
  task automatic t_timing();
    int per;
    int hi;
    per = 0;
    hi = 0;
    wait_lvl(rdy_n, 1'b1, 4000);
    wait_lvl(rdy_n, 1'b0, 4000);
    while (rdy_n === 1'b0 && per < 3000) begin
      @(negedge clk);
      per++;
    end
    while (rdy_n === 1'b1 && per < 3000) begin
      @(negedge clk);
      per++;
      hi++;
    end
    check("lead", 32'(hi), 32'(READY_LEAD));
    check("period", 32'(per), 32'(CONVERT_REQUEST_CYCLES));
  endtask : t_timing
  task automatic t_self_full();
    HOST.bits = 0;
    drive_sel(1'b0);
    wait_lvl(rdy_n, 1'b1, 300);
    check("self word", 32'(HOST.word), 32'h0000a5c3);
    check("self bits", 32'(HOST.bits), 32'(W));
    check("self oe", 32'(sclk_oe), 32'h0);
  endtask : t_self_full
  task automatic t_self_part();
    HOST.bits = 0;
    for (int i = 0; i < 4000 && HOST.bits < 5; i++) @(negedge clk);
    drive_sel(1'b1);
    repeat (10) @(negedge clk);
    check("part oe", 32'(sclk_oe), 32'h0);
    check("part short", 32'(HOST.bits < W), 32'h1);
    drive_sel(1'b0);
    wait_lvl(rdy_n, 1'b1, 300);
    check("resume word", 32'(HOST.word), 32'h0000a5c3);
    check("resume bits", 32'(HOST.bits), 32'(W));
  endtask : t_self_part
  task automatic t_host();
    drive_sel(1'b1);
    mode = MODE_GND;
    bip = 1'b1;
    res = 16'h1234;
    wait_lvl(rdy_n, 1'b1, 4000);
    wait_lvl(rdy_n, 1'b0, 4000);
    drive_sel(1'b0);
    wait_lvl(sdo_oe, 1'b1, 20);
    check("host msb", 32'(sdo), 32'h1);
    check("host no clk", 32'(sclk_oe), 32'h0);
    HOST.ext_read();
    repeat (8) @(negedge clk);
    check("host word", 32'(HOST.word), 32'h00009234);
    check("host oe", 32'(sdo_oe), 32'h0);
    check("host ready", 32'(rdy_n), 32'h1);
    drive_sel(1'b1);
  endtask : t_host
  task automatic end_of_test();
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #200000;
    failures++;
    end_of_test();
  end
  initial begin
    failures = 0;
    check_count = 0;
    nrst = 1'b0;
    sel_n = 1'b1;
    req = 1'b1;
    bip = 1'b0;
    mode = MODE_SUP;
    res = 16'ha5c3;
    repeat (20) @(posedge clk);
    #1 nrst = 1'b1;
    t_timing();
    t_self_full();
    t_self_part();
    t_host();
    end_of_test();
  end
endmodule : adcsp_port_tb_top
`default_nettype wire
